// ---- rtl/iosba_bank.sv ----
// Purpose: lower io register bank with byte and single-bit access from the core
// Assumes: core requests come from logic on i_clk_sys; pins are asynchronous
// Notes:   answer one cycle after the request; set by hardware wins over clear
`timescale 1ns/1ps
`include "iosba_cfg.svh"
module iosba_bank
	import iosba_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_nrst,
	// core access port
	input  wire logic       i_acc_valid,
	input  wire iosba_op_t  i_acc_op,
	input  wire logic       i_acc_space,
	input  wire logic [7:0] i_acc_addr,
	input  wire logic [2:0] i_acc_bit,
	input  wire logic [7:0] i_acc_wdata,
	output logic      [7:0] o_acc_rdata,
	output logic            o_acc_done,
	output logic            o_acc_skip,
	output logic            o_acc_err,
	// peripheral events and status
	input  wire logic [2:0] i_tmr1_evt,
	input  wire logic       i_cnv_done,
	input  wire logic       i_cmp_evt,
	input  wire logic       i_cmp_out,
	input  wire logic       i_sh_start,
	input  wire logic       i_sh_ovf,
	input  wire logic       i_sh_stop,
	input  wire logic       i_sh_coll,
	input  wire logic [7:0] i_res_lo,
	input  wire logic [7:0] i_res_hi,
	input  wire logic [7:0] i_sh_buf,
	input  wire logic [7:0] i_pin_a,
	input  wire logic [7:0] i_pin_b,
	// register contents to the peripherals
	output logic      [7:0] o_pwr_red,
	output logic      [7:0] o_dig_dis,
	output logic      [7:0] o_cnv_ctl_b,
	output logic      [7:0] o_cnv_ctl_a,
	output logic      [7:0] o_cnv_sel,
	output logic      [7:0] o_cmp_ctl,
	output logic      [7:0] o_tmr1_flags,
	output logic      [7:0] o_tmr1_mask,
	output logic      [7:0] o_sh_ctl,
	output logic      [7:0] o_sh_sta,
	output logic      [7:0] o_sh_data,
	output logic      [7:0] o_pcm_lo,
	output logic      [7:0] o_pcm_hi,
	output logic      [7:0] o_pa_dir,
	output logic      [7:0] o_pa_out,
	output logic      [7:0] o_pb_dir,
	output logic      [7:0] o_pb_out,
	output logic      [7:0] o_nv_ctl,
	output logic      [7:0] o_nv_data,
	output logic      [7:0] o_nv_addr
);
	iosba_bank_state_t st_reg;
	iosba_bank_state_t st_next;

	logic [7:0] pin_a_s;
	logic [7:0] pin_b_s;
	logic [6:0] dec;
	logic       acc_hit;
	logic [5:0] acc_idx;
	logic       acc_rsv;
	logic       bit_ok;
	logic [7:0] rd_val;
	logic [7:0] cur_val;
	logic [7:0] merged;

	// map an address of either space onto an io index with a hit flag
	function automatic logic [6:0] iosba_decode(input logic space, input logic [7:0] addr);
		logic [7:0] a;
		logic       ok;
		a  = space ? (addr - `IOSBA_DATA_OFS) : addr;
		ok = space ? (addr >= `IOSBA_DATA_OFS) : 1'b1;
		ok = ok && (a <= {2'b00, `IOSBA_LAST_REG});
		iosba_decode = {ok, a[5:0]};
	endfunction : iosba_decode

	// addresses with no register behind them
	function automatic logic iosba_reserved(input logic [5:0] idx);
		case (idx)
			`IOSBA_OFS_RSV_02,
			`IOSBA_OFS_RSV_09,
			`IOSBA_OFS_RSV_0A,
			`IOSBA_OFS_RSV_11,
			`IOSBA_OFS_RSV_1F: iosba_reserved = 1'b1;
			default:           iosba_reserved = 1'b0;
		endcase
	endfunction : iosba_reserved

	// bits that software stores
	function automatic logic [7:0] iosba_rw_mask(input logic [5:0] idx);
		case (idx)
			`IOSBA_OFS_PWR_RED: iosba_rw_mask = `IOSBA_RW_PWR_RED;
			`IOSBA_OFS_DIG_DIS: iosba_rw_mask = `IOSBA_RW_DIG_DIS;
			`IOSBA_OFS_CNV_B:   iosba_rw_mask = `IOSBA_RW_CNV_B;
			`IOSBA_OFS_CNV_A:   iosba_rw_mask = `IOSBA_RW_CNV_A;
			`IOSBA_OFS_CNV_SEL: iosba_rw_mask = `IOSBA_RW_CNV_SEL;
			`IOSBA_OFS_CMP:     iosba_rw_mask = `IOSBA_RW_CMP;
			`IOSBA_OFS_T1_MSK:  iosba_rw_mask = `IOSBA_RW_T1_MSK;
			`IOSBA_OFS_SH_STA:  iosba_rw_mask = `IOSBA_RW_SH_STA;
			`IOSBA_OFS_NV_CTL:  iosba_rw_mask = `IOSBA_RW_NV_CTL;
			`IOSBA_OFS_NV_ADR:  iosba_rw_mask = `IOSBA_RW_NV_ADR;
			`IOSBA_OFS_SH_CTL,
			`IOSBA_OFS_SH_DAT,
			`IOSBA_OFS_PCM_LO,
			`IOSBA_OFS_SCR0,
			`IOSBA_OFS_SCR1,
			`IOSBA_OFS_SCR2,
			`IOSBA_OFS_PB_DIR,
			`IOSBA_OFS_PB_OUT,
			`IOSBA_OFS_PA_DIR,
			`IOSBA_OFS_PA_OUT,
			`IOSBA_OFS_NV_DAT,
			`IOSBA_OFS_PCM_HI:  iosba_rw_mask = `IOSBA_RW_FULL;
			default:            iosba_rw_mask = 8'h00;
		endcase
	endfunction : iosba_rw_mask

	// status flags that clear when one is written
	function automatic logic [7:0] iosba_w1c_mask(input logic [5:0] idx);
		case (idx)
			`IOSBA_OFS_CNV_A:  iosba_w1c_mask = `IOSBA_W1_CNV_A;
			`IOSBA_OFS_CMP:    iosba_w1c_mask = `IOSBA_W1_CMP;
			`IOSBA_OFS_T1_FLG: iosba_w1c_mask = `IOSBA_W1_T1_FLG;
			`IOSBA_OFS_SH_STA: iosba_w1c_mask = `IOSBA_W1_SH_STA;
			default:           iosba_w1c_mask = 8'h00;
		endcase
	endfunction : iosba_w1c_mask

	// bit test result: skip when the tested bit has the wanted level
	function automatic logic iosba_skip_hit(input logic [7:0] v, input logic [2:0] b, input logic want);
		iosba_skip_hit = (v[b] == want);
	endfunction : iosba_skip_hit

	// pin groups pass two flip-flops before the read path
	iosba_sync u_sync_a (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_d       (i_pin_a),
		.o_q       (pin_a_s)
	);

	iosba_sync u_sync_b (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_d       (i_pin_b),
		.o_q       (pin_b_s)
	);

	// address decode of the current request
	assign dec     = iosba_decode(i_acc_space, i_acc_addr);
	assign acc_hit = dec[6];
	assign acc_idx = dec[6] ? dec[5:0] : 6'h00;
	assign acc_rsv = iosba_reserved(acc_idx);
	assign bit_ok  = acc_hit && (acc_idx <= `IOSBA_BIT_TOP);
	assign cur_val = st_reg.regs[acc_idx];

	// read value: stored bits, hardware-owned bits, zero for reserved
	always_comb begin
		rd_val = cur_val & (iosba_rw_mask(acc_idx) | iosba_w1c_mask(acc_idx));
		case (acc_idx)
			`IOSBA_OFS_RES_LO: rd_val = i_res_lo;
			`IOSBA_OFS_RES_HI: rd_val = i_res_hi;
			`IOSBA_OFS_SH_BUF: rd_val = i_sh_buf;
			`IOSBA_OFS_PB_IN:  rd_val = pin_b_s;
			`IOSBA_OFS_PA_IN:  rd_val = pin_a_s;
			`IOSBA_OFS_CMP:    rd_val[`IOSBA_BIT_CMP_OUT] = i_cmp_out;
			`IOSBA_OFS_SH_STA: rd_val[`IOSBA_BIT_SH_COLL] = i_sh_coll;
			default:           rd_val = rd_val;
		endcase
		if (!acc_hit) begin
			rd_val = 8'h00;
		end
	end

	// byte write or single-bit update of the addressed register
	iosba_merge u_merge (
		.i_cur      (cur_val),
		.i_op       (i_acc_op),
		.i_bit      (i_acc_bit),
		.i_wdata    (i_acc_wdata),
		.i_rw_mask  (iosba_rw_mask(acc_idx)),
		.i_w1c_mask (iosba_w1c_mask(acc_idx)),
		.o_next     (merged)
	);

	// access handling, then hardware events so a set beats a clear
	always_comb begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		st_next.skip = 1'b0;
		st_next.err  = 1'b0;
		if (i_acc_valid) begin
			st_next.done  = 1'b1;
			st_next.rdata = rd_val;
			if (!acc_hit) begin
				st_next.err = 1'b1;
			end else begin
				case (i_acc_op)
					IOSBA_OP_READ: begin
						st_next.err = 1'b0;
					end
					IOSBA_OP_WRITE: begin
						if (acc_rsv) begin
							st_next.err = 1'b1;
						end else begin
							st_next.regs[acc_idx] = merged;
						end
					end
					IOSBA_OP_SET_BIT,
					IOSBA_OP_CLEAR_BIT: begin
						if (!bit_ok || acc_rsv) begin
							st_next.err = 1'b1;
						end else begin
							st_next.regs[acc_idx] = merged;
						end
					end
					IOSBA_OP_SKIP_ONE: begin
						if (!bit_ok) begin
							st_next.err = 1'b1;
						end else begin
							st_next.skip = iosba_skip_hit(rd_val, i_acc_bit, 1'b1);
						end
					end
					IOSBA_OP_SKIP_ZERO: begin
						if (!bit_ok) begin
							st_next.err = 1'b1;
						end else begin
							st_next.skip = iosba_skip_hit(rd_val, i_acc_bit, 1'b0);
						end
					end
					default: begin
						st_next.err = 1'b1;
					end
				endcase
			end
		end
		// event flags set after the clear
		st_next.regs[`IOSBA_OFS_T1_FLG] = st_next.regs[`IOSBA_OFS_T1_FLG] | {5'h00, i_tmr1_evt};
		if (i_cnv_done) begin
			st_next.regs[`IOSBA_OFS_CNV_A][`IOSBA_BIT_CNV_DONE] = 1'b1;
		end
		if (i_cmp_evt) begin
			st_next.regs[`IOSBA_OFS_CMP][`IOSBA_BIT_CMP_EVT] = 1'b1;
		end
		if (i_sh_start) begin
			st_next.regs[`IOSBA_OFS_SH_STA][`IOSBA_BIT_SH_START] = 1'b1;
		end
		if (i_sh_ovf) begin
			st_next.regs[`IOSBA_OFS_SH_STA][`IOSBA_BIT_SH_OVF] = 1'b1;
		end
		if (i_sh_stop) begin
			st_next.regs[`IOSBA_OFS_SH_STA][`IOSBA_BIT_SH_STOP] = 1'b1;
		end
	end

	// state register
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg.regs  <= {33{`IOSBA_RST_VAL}};
			st_reg.rdata <= 8'h00;
			st_reg.done  <= 1'b0;
			st_reg.skip  <= 1'b0;
			st_reg.err   <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// core answer
	assign o_acc_rdata = st_reg.rdata;
	assign o_acc_done  = st_reg.done;
	assign o_acc_skip  = st_reg.skip;
	assign o_acc_err   = st_reg.err;

	// register contents to the peripherals
	assign o_pwr_red    = st_reg.regs[`IOSBA_OFS_PWR_RED];
	assign o_dig_dis    = st_reg.regs[`IOSBA_OFS_DIG_DIS];
	assign o_cnv_ctl_b  = st_reg.regs[`IOSBA_OFS_CNV_B];
	assign o_cnv_ctl_a  = st_reg.regs[`IOSBA_OFS_CNV_A];
	assign o_cnv_sel    = st_reg.regs[`IOSBA_OFS_CNV_SEL];
	assign o_cmp_ctl    = st_reg.regs[`IOSBA_OFS_CMP];
	assign o_tmr1_flags = st_reg.regs[`IOSBA_OFS_T1_FLG];
	assign o_tmr1_mask  = st_reg.regs[`IOSBA_OFS_T1_MSK];
	assign o_sh_ctl     = st_reg.regs[`IOSBA_OFS_SH_CTL];
	assign o_sh_sta     = st_reg.regs[`IOSBA_OFS_SH_STA];
	assign o_sh_data    = st_reg.regs[`IOSBA_OFS_SH_DAT];
	assign o_pcm_lo     = st_reg.regs[`IOSBA_OFS_PCM_LO];
	assign o_pcm_hi     = st_reg.regs[`IOSBA_OFS_PCM_HI];
	assign o_pa_dir     = st_reg.regs[`IOSBA_OFS_PA_DIR];
	assign o_pa_out     = st_reg.regs[`IOSBA_OFS_PA_OUT];
	assign o_pb_dir     = st_reg.regs[`IOSBA_OFS_PB_DIR];
	assign o_pb_out     = st_reg.regs[`IOSBA_OFS_PB_OUT];
	assign o_nv_ctl     = st_reg.regs[`IOSBA_OFS_NV_CTL];
	assign o_nv_data    = st_reg.regs[`IOSBA_OFS_NV_DAT];
	assign o_nv_addr    = st_reg.regs[`IOSBA_OFS_NV_ADR];
endmodule : iosba_bank

// ---- pkg/iosba_cfg.svh ----
// Purpose: constants of the lower io register bank with single-bit access
// Assumes: io addresses 0x00..0x20, data space alias at io address plus 0x20
// Notes:   masks give the writable and write-one-to-clear bits of each register
//
// Behaviour
// - bit set and clear work on io 0x00..0x1F except the reserved addresses, refused elsewhere
// - bit test with skip result works on io 0x00..0x1F
// - status flags clear on writing one; writing zero leaves them unchanged
// - bit set or clear changes only the addressed bit, nothing written back
`ifndef IOSBA_CFG_SVH
`define IOSBA_CFG_SVH

`define IOSBA_DATA_OFS    8'h20
`define IOSBA_BIT_TOP     6'h1F
`define IOSBA_LAST_REG    6'h20
`define IOSBA_RST_VAL     8'h00

// register offsets
`define IOSBA_OFS_PWR_RED 6'h00
`define IOSBA_OFS_DIG_DIS 6'h01
`define IOSBA_OFS_RSV_02  6'h02
`define IOSBA_OFS_CNV_B   6'h03
`define IOSBA_OFS_RES_LO  6'h04
`define IOSBA_OFS_RES_HI  6'h05
`define IOSBA_OFS_CNV_A   6'h06
`define IOSBA_OFS_CNV_SEL 6'h07
`define IOSBA_OFS_CMP     6'h08
`define IOSBA_OFS_RSV_09  6'h09
`define IOSBA_OFS_RSV_0A  6'h0A
`define IOSBA_OFS_T1_FLG  6'h0B
`define IOSBA_OFS_T1_MSK  6'h0C
`define IOSBA_OFS_SH_CTL  6'h0D
`define IOSBA_OFS_SH_STA  6'h0E
`define IOSBA_OFS_SH_DAT  6'h0F
`define IOSBA_OFS_SH_BUF  6'h10
`define IOSBA_OFS_RSV_11  6'h11
`define IOSBA_OFS_PCM_LO  6'h12
`define IOSBA_OFS_SCR0    6'h13
`define IOSBA_OFS_SCR1    6'h14
`define IOSBA_OFS_SCR2    6'h15
`define IOSBA_OFS_PB_IN   6'h16
`define IOSBA_OFS_PB_DIR  6'h17
`define IOSBA_OFS_PB_OUT  6'h18
`define IOSBA_OFS_PA_IN   6'h19
`define IOSBA_OFS_PA_DIR  6'h1A
`define IOSBA_OFS_PA_OUT  6'h1B
`define IOSBA_OFS_NV_CTL  6'h1C
`define IOSBA_OFS_NV_DAT  6'h1D
`define IOSBA_OFS_NV_ADR  6'h1E
`define IOSBA_OFS_RSV_1F  6'h1F
`define IOSBA_OFS_PCM_HI  6'h20

// writable and clear-on-one bit masks
`define IOSBA_RW_FULL     8'hFF
`define IOSBA_RW_PWR_RED  8'h0F
`define IOSBA_RW_DIG_DIS  8'h3F
`define IOSBA_RW_CNV_B    8'hD7
`define IOSBA_RW_CNV_A    8'hEF
`define IOSBA_W1_CNV_A    8'h10
`define IOSBA_RW_CNV_SEL  8'h47
`define IOSBA_RW_CMP      8'hCB
`define IOSBA_W1_CMP      8'h10
`define IOSBA_W1_T1_FLG   8'h07
`define IOSBA_RW_T1_MSK   8'h07
`define IOSBA_RW_SH_STA   8'h0F
`define IOSBA_W1_SH_STA   8'hE0
`define IOSBA_RW_NV_CTL   8'h3F
`define IOSBA_RW_NV_ADR   8'h3F

// flag and status bit positions
`define IOSBA_BIT_CNV_DONE 3'h4
`define IOSBA_BIT_CMP_EVT  3'h4
`define IOSBA_BIT_CMP_OUT  3'h5
`define IOSBA_BIT_SH_START 3'h7
`define IOSBA_BIT_SH_OVF   3'h6
`define IOSBA_BIT_SH_STOP  3'h5
`define IOSBA_BIT_SH_COLL  3'h4

`endif

// ---- pkg/iosba_pkg.sv ----
// Purpose: types of the lower io register bank
// Assumes: 33 byte registers at io 0x00..0x20
// Notes:   access op codes are driven by the core each request
package iosba_pkg;
	typedef enum logic [2:0] {
		IOSBA_OP_READ      = 3'h0,
		IOSBA_OP_WRITE     = 3'h1,
		IOSBA_OP_SET_BIT   = 3'h2,
		IOSBA_OP_CLEAR_BIT = 3'h3,
		IOSBA_OP_SKIP_ONE  = 3'h4,
		IOSBA_OP_SKIP_ZERO = 3'h5
	} iosba_op_t;

	typedef struct packed {
		logic [32:0][7:0] regs;
		logic [7:0]       rdata;
		logic             done;
		logic             skip;
		logic             err;
	} iosba_bank_state_t;

	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
	} iosba_sync_state_t;
endpackage : iosba_pkg

// ---- rtl/iosba_sync.sv ----
// Purpose: two flip-flop synchroniser for one group of eight pins
// Assumes: pins change freely with respect to the system clock
// Notes:   only the second stage is visible outside
`timescale 1ns/1ps
module iosba_sync
	import iosba_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_nrst,
	input  wire logic [7:0] i_d,
	output logic      [7:0] o_q
);
	iosba_sync_state_t st_reg;
	iosba_sync_state_t st_next;

	// first stage feeds the second only
	always_comb begin
		st_next    = st_reg;
		st_next.s1 = i_d;
		st_next.s2 = st_reg.s1;
	end

	// state register
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_q = st_reg.s2;
endmodule : iosba_sync

// ---- rtl/iosba_merge.sv ----
// Purpose: new value of one register for a byte write or a single-bit op
// Assumes: masks come from the bank's address decode
// Notes:   purely combinational, holds no state
`timescale 1ns/1ps
module iosba_merge
	import iosba_pkg::*;
(
	input  wire logic       [7:0] i_cur,
	input  wire iosba_op_t        i_op,
	input  wire logic       [2:0] i_bit,
	input  wire logic       [7:0] i_wdata,
	input  wire logic       [7:0] i_rw_mask,
	input  wire logic       [7:0] i_w1c_mask,
	output logic            [7:0] o_next
);
	logic [7:0] sel;
	logic [7:0] val;

	// a bit op touches only its own bit, a byte write all bits
	always_comb begin
		sel = 8'hFF;
		val = i_wdata;
		if (i_op == IOSBA_OP_SET_BIT || i_op == IOSBA_OP_CLEAR_BIT) begin
			sel = 8'h01 << i_bit;
			val = (i_op == IOSBA_OP_SET_BIT) ? 8'hFF : 8'h00;
		end
	end

	// writable bits take the value, flag bits clear on one only
	assign o_next = ((i_cur & ~(sel & i_rw_mask)) | (val & sel & i_rw_mask))
		& ~(val & sel & i_w1c_mask);
endmodule : iosba_merge

// ---- sim/iosba_chk_sva.sv ----
// Purpose: port checks of the lower io register bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every iosba_bank instance
`timescale 1ns/1ps
module iosba_chk
	import iosba_pkg::*;
(
	input wire logic       i_clk_sys,
	input wire logic       i_nrst,
	input wire logic       i_acc_valid,
	input wire iosba_op_t  i_acc_op,
	input wire logic       i_acc_space,
	input wire logic [7:0] i_acc_addr,
	input wire logic [2:0] i_acc_bit,
	input wire logic [7:0] i_acc_wdata,
	input wire logic [7:0] o_acc_rdata,
	input wire logic       o_acc_done,
	input wire logic       o_acc_skip,
	input wire logic       o_acc_err,
	input wire logic [2:0] i_tmr1_evt,
	input wire logic [7:0] o_tmr1_flags,
	input wire logic [7:0] o_pa_out
);
	// every check on the system clock, quiet during reset
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	// decode of the request in flight
	logic       pa_hit, t1_hit, io_hi;
	logic [7:0] bmask;
	logic [2:0] flo, wlo, blo;
	assign pa_hit = i_acc_space ? i_acc_addr == 8'h3B : i_acc_addr == 8'h1B;
	assign t1_hit = !i_acc_space && i_acc_addr == 8'h0B;
	assign io_hi  = !i_acc_space && i_acc_addr > 8'h1F;
	assign bmask  = 8'h01 << i_acc_bit;
	assign flo    = o_tmr1_flags[2:0];
	assign wlo    = i_acc_wdata[2:0];
	assign blo    = bmask[2:0];
	// answer timing, refusals, skip results and register updates
	a_done_latency: assert property (i_acc_valid |=> o_acc_done) else $error("no done after request");
	a_done_idle: assert property (!i_acc_valid |=> !o_acc_done && !o_acc_err) else $error("done without request");
	a_bit_range: assert property (
		i_acc_valid && io_hi && i_acc_op >= IOSBA_OP_SET_BIT |=> o_acc_err && !o_acc_skip)
		else $error("bit access above range taken");
	a_skip_one: assert property (
		i_acc_valid && i_acc_op == IOSBA_OP_SKIP_ONE |=> o_acc_err || o_acc_skip == o_acc_rdata[$past(i_acc_bit)])
		else $error("skip result wrong");
	a_pa_bitop: assert property (
		i_acc_valid && pa_hit && i_acc_op inside {IOSBA_OP_SET_BIT, IOSBA_OP_CLEAR_BIT} |=> o_pa_out ==
		($past(i_acc_op) == IOSBA_OP_SET_BIT ? $past(o_pa_out) | $past(bmask) : $past(o_pa_out) & ~$past(bmask)))
		else $error("bit op touched other bits");
	a_alias_write: assert property (
		i_acc_valid && pa_hit && i_acc_op == IOSBA_OP_WRITE |=> !o_acc_err ##0 o_pa_out == $past(i_acc_wdata))
		else $error("aliased write lost");
	a_flag_write: assert property (
		i_acc_valid && t1_hit && i_acc_op == IOSBA_OP_WRITE |=> flo == (($past(flo) & ~$past(wlo)) | $past(i_tmr1_evt)))
		else $error("flag write wrong");
	a_flag_bitop: assert property (
		i_acc_valid && t1_hit && i_acc_op == IOSBA_OP_SET_BIT |=> flo == (($past(flo) & ~$past(blo)) | $past(i_tmr1_evt)))
		else $error("flag bit op wrong");
endmodule : iosba_chk

bind iosba_bank iosba_chk u_chk (.i_clk_sys, .i_nrst, .i_acc_valid, .i_acc_op, .i_acc_space, .i_acc_addr,
	.i_acc_bit, .i_acc_wdata, .o_acc_rdata, .o_acc_done, .o_acc_skip, .o_acc_err, .i_tmr1_evt, .o_tmr1_flags,
	.o_pa_out);

// ---- sim/iosba_core_model.sv ----
// Purpose: core issuing io access instructions to the bank
// Assumes: one request at a time, answer one cycle after taking
// Notes:   released write data is inverted so stale bytes never match
`timescale 1ns/1ps
module iosba_core_model
	import iosba_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_done,
	input  wire logic       i_skip,
	input  wire logic       i_err,
	output logic            o_valid,
	output iosba_op_t       o_op,
	output logic            o_space,
	output logic [7:0]      o_addr,
	output logic [2:0]      o_bit,
	output logic [7:0]      o_wdata
);
	// idle port
	initial begin
		{o_valid, o_space, o_addr, o_bit, o_wdata} = '0;
		o_op = IOSBA_OP_READ;
	end

	// one instruction: ans is done, skip, err, read byte
	task automatic run(input iosba_op_t op, input logic sp, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] wd, output logic [10:0] ans);
		ans = 11'h000;
		if (op == IOSBA_OP_WRITE && (sp ? a - 8'h20 : a) inside {8'h02, 8'h09, 8'h0A, 8'h11, 8'h1F})
			return;
		@(posedge i_clk_sys);
		o_valid <= 1'b1;
		o_op    <= op;
		o_space <= sp;
		o_addr  <= a;
		o_bit   <= b;
		o_wdata <= wd;
		@(posedge i_clk_sys);
		o_valid <= 1'b0;
		o_wdata <= ~wd;
		@(negedge i_clk_sys);
		ans = {i_done, i_skip, i_err, i_rdata};
	endtask : run
endmodule : iosba_core_model

// ---- sim/testbench.sv ----
// Purpose: self-checking bench of the lower io register bank
// Assumes: core model drives the access port
// Notes:   random data from a fixed seed, corner cases by hand
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	checked++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("Error %s exp %h got %h", nm, e, g); \
	end \
end
module testbench
	import iosba_pkg::*;
;
	logic        clk, nrst, valid, space, done, skip, err, sp;
	iosba_op_t   op, o;
	logic [2:0]  bsel, b;
	logic [7:0]  addr, wdata, rdata, pa_out, t1_f, pcm_hi, cnv_a, a, d, pa, pcm;
	logic [9:0]  ev;
	logic [39:0] dv;
	logic [10:0] ans;
	logic [8:0]  r;
	int          seed = 57280;
	int          n_fail = 0;
	int          checked = 0;
	logic [7:0]  rwl [19] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0C, 8'h0D, 8'h0F, 8'h12, 8'h13, 8'h14, 8'h15,
		8'h17, 8'h18, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h20};
	logic [7:0]  rol [5] = '{8'h04, 8'h05, 8'h10, 8'h19, 8'h16};
	// io address behind each byte of the raw register outputs
	logic [7:0]  oal [16] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h08, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h12, 8'h1A,
		8'h17, 8'h18, 8'h1C, 8'h1D, 8'h1E};
	wire  [127:0] ro;

	iosba_bank dut (
		.i_clk_sys(clk), .i_nrst(nrst), .i_acc_valid(valid), .i_acc_op(op), .i_acc_space(space),
		.i_acc_addr(addr), .i_acc_bit(bsel), .i_acc_wdata(wdata), .o_acc_rdata(rdata), .o_acc_done(done),
		.o_acc_skip(skip), .o_acc_err(err), .i_tmr1_evt(ev[2:0]), .i_cnv_done(ev[3]), .i_cmp_evt(ev[4]),
		.i_cmp_out(ev[5]), .i_sh_start(ev[6]), .i_sh_ovf(ev[7]), .i_sh_stop(ev[8]), .i_sh_coll(ev[9]),
		.i_res_lo(dv[7:0]), .i_res_hi(dv[15:8]), .i_sh_buf(dv[23:16]), .i_pin_a(dv[31:24]),
		.i_pin_b(dv[39:32]), .o_pwr_red(ro[7:0]), .o_dig_dis(ro[15:8]), .o_cnv_ctl_b(ro[23:16]),
		.o_cnv_ctl_a(cnv_a), .o_cnv_sel(ro[31:24]), .o_cmp_ctl(ro[39:32]), .o_tmr1_flags(t1_f),
		.o_tmr1_mask(ro[47:40]), .o_sh_ctl(ro[55:48]), .o_sh_sta(ro[63:56]), .o_sh_data(ro[71:64]),
		.o_pcm_lo(ro[79:72]), .o_pcm_hi(pcm_hi), .o_pa_dir(ro[87:80]), .o_pa_out(pa_out), .o_pb_dir(ro[95:88]),
		.o_pb_out(ro[103:96]), .o_nv_ctl(ro[111:104]), .o_nv_data(ro[119:112]), .o_nv_addr(ro[127:120])
	);
	iosba_core_model core (
		.i_clk_sys(clk), .i_rdata(rdata), .i_done(done), .i_skip(skip), .i_err(err), .o_valid(valid),
		.o_op(op), .o_space(space), .o_addr(addr), .o_bit(bsel), .o_wdata(wdata)
	);

	// writable bits of each plain register
	function automatic logic [7:0] wmask(input logic [7:0] fa);
		case (fa)
			8'h00: return 8'h0F;
			8'h01, 8'h1C, 8'h1E: return 8'h3F;
			8'h03: return 8'hD7;
			8'h07: return 8'h47;
			8'h0C: return 8'h07;
			default: return 8'hFF;
		endcase
	endfunction : wmask

	// skip result and new value of a single-bit op
	function automatic logic [8:0] bitop(input iosba_op_t fo, input logic [7:0] v, input logic [2:0] fb);
		case (fo)
			IOSBA_OP_SET_BIT: return {1'b0, v | (8'h01 << fb)};
			IOSBA_OP_CLEAR_BIT: return {1'b0, v & ~(8'h01 << fb)};
			IOSBA_OP_SKIP_ONE: return {v[fb], v};
			default: return {~v[fb], v};
		endcase
	endfunction : bitop

	// one access on timer1 flags, then compare them
	task automatic flag(input iosba_op_t fo, input logic [2:0] fb, input logic [7:0] fd, input logic [7:0] fe);
		core.run(fo, 1'b0, 8'h0B, fb, fd, ans);
		`CHK("timer1 flags", fe, t1_f)
	endtask : flag

	// verdict and end of run
	task automatic end_sim;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// system clock, 50 ns
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// cut a hung run short
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		end_sim;
	end

	// main sequence
	initial begin
		ev   = 10'h000;
		dv   = {$random(seed), 8'($random(seed))};
		nrst = 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		`CHK("reset value", 8'h00, pa_out)
		// byte writes read back through the other address space
		foreach (rwl[i]) begin
			a  = rwl[i];
			sp = 1'($random(seed));
			d  = 8'($random(seed)) & wmask(a);
			core.run(IOSBA_OP_WRITE, sp, a + (sp ? 8'h20 : 8'h00), 3'h0, d, ans);
			core.run(IOSBA_OP_READ, !sp, a + (sp ? 8'h00 : 8'h20), 3'h0, 8'h00, ans);
			`CHK("readback", {3'b100, d}, ans)
			foreach (oal[j]) if (oal[j] == a) `CHK("raw register", d, ro[8*j+:8])
			if (a == 8'h1B) pa = d;
			if (a == 8'h20) pcm = d;
		end
		// random single-bit ops and tests on the port a output register
		repeat (32) begin
			b  = 3'($random(seed));
			sp = 1'($random(seed));
			o  = iosba_op_t'(3'h2 + {1'b0, 2'($random(seed))});
			r  = bitop(o, pa, b);
			core.run(o, sp, sp ? 8'h3B : 8'h1B, b, 8'h00, ans);
			`CHK("bit op answer", {1'b1, r[8], 1'b0, pa}, ans)
			pa = r[7:0];
			`CHK("port a output", pa, pa_out)
		end
		// bit ops and tests above the bit-accessible range
		for (int k = 2; k < 8; k++) begin
			core.run(iosba_op_t'(k), k[0], k[0] ? 8'h40 : 8'h20, 3'h1, 8'h00, ans);
			`CHK("refused", 1'b1, ans[8])
			`CHK("pcm_hi kept", pcm, pcm_hi)
		end
		// unmapped data address refused, reserved io address reads zero
		core.run(IOSBA_OP_READ, 1'b1, 8'h10, 3'h0, 8'h00, ans);
		`CHK("unmapped read", 11'h500, ans)
		core.run(IOSBA_OP_READ, 1'b0, 8'h09, 3'h0, 8'h00, ans);
		`CHK("reserved read", 11'h400, ans)
		// raise every event for one cycle, then clear flags by several means
		@(posedge clk);
		ev <= 10'h3FF;
		@(posedge clk);
		ev <= 10'h000;
		flag(IOSBA_OP_WRITE, 3'h0, 8'h02, 8'h05);
		flag(IOSBA_OP_WRITE, 3'h0, 8'h00, 8'h05);
		flag(IOSBA_OP_SET_BIT, 3'h0, 8'h00, 8'h04);
		flag(IOSBA_OP_CLEAR_BIT, 3'h2, 8'h00, 8'h04);
		core.run(IOSBA_OP_SET_BIT, 1'b0, 8'h06, 3'h0, 8'h00, ans);
		`CHK("converter flag kept", 8'h11, cnv_a)
		// live bits read through, and a flag raised in the cycle of its clear stays set
		@(posedge clk);
		ev <= 10'h2A0;
		core.run(IOSBA_OP_READ, 1'b0, 8'h08, 3'h0, 8'h00, ans);
		`CHK("comparator read", {3'b100, 8'h30}, ans)
		core.run(IOSBA_OP_READ, 1'b1, 8'h2E, 3'h0, 8'h00, ans);
		`CHK("shifter status read", {3'b100, 8'hF0}, ans)
		`CHK("shifter status raw", 8'hE0, ro[63:56])
		core.run(IOSBA_OP_WRITE, 1'b0, 8'h0E, 3'h0, 8'hE0, ans);
		`CHK("shifter flags cleared", 8'h40, ro[63:56])
		core.run(IOSBA_OP_WRITE, 1'b1, 8'h28, 3'h0, 8'h10, ans);
		`CHK("comparator flag cleared", 8'h00, ro[39:32])
		// live and synchronised inputs read through the bank
		@(posedge clk);
		dv <= {$random(seed), 8'($random(seed))};
		ev <= 10'h000;
		repeat (3) @(posedge clk);
		foreach (rol[i]) begin
			core.run(IOSBA_OP_READ, 1'b0, rol[i], 3'h0, 8'h00, ans);
			`CHK("live read", {3'b100, dv[8*i+:8]}, ans)
		end
		end_sim;
	end
endmodule : testbench
